// ### hdl/fcc_pkg.sv
// package of constants and types for the field coprocessor control register bank
package fcc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_IMEM_BASE = 8'h00;
   localparam logic [7:0] OFS_DMEM_BASE = 8'h04;
   localparam logic [7:0] OFS_DMEM_LOG2 = 8'h08;
   localparam logic [7:0] OFS_IMEM_LOG2 = 8'h0c;
   localparam logic [7:0] OFS_IPTR = 8'h10;
   localparam logic [7:0] OFS_LAST_CYC = 8'h14;
   // fields of the reset control write
   localparam int BIT_IMEM_RST = 0;
   localparam int BIT_DMEM_RST = 1;
   // host address map defaults
   localparam logic [31:0] IMEM_BASE_DEF = 32'h0000_1000;
   localparam logic [31:0] DMEM_BASE_DEF = 32'h0001_0000;
   localparam int DMEM_LOG2_DEF = 8;
   localparam int IMEM_LOG2_DEF = 8;
   // element and word geometry
   localparam int BUS_W = 381;
   localparam int SLOT_BYTES = 48;
   localparam int SLOT_SPAN = 64;
   localparam int INSTR_BYTES = 8;
   localparam int SLOT_W = SLOT_BYTES * 8;
   localparam int INSTR_W = INSTR_BYTES * 8;
   // opcodes
   localparam logic [7:0] OP_IDLE_STALL = 8'h00;
   localparam logic [7:0] OP_COPY = 8'h01;
   localparam logic [7:0] OP_JUMP = 8'h02;
   localparam logic [7:0] OP_MUL = 8'h10;
   localparam logic [7:0] OP_ADD = 8'h11;
   localparam logic [7:0] OP_SUB = 8'h12;
   // arithmetic pipeline timing
   localparam int KARA_LEVELS = 3;
   localparam int STAGES_PER_LEVEL = 3;
   localparam int MUL_LAT = KARA_LEVELS * STAGES_PER_LEVEL;
   localparam int RED_LAT = 2 * MUL_LAT;
   localparam int ADD_LAT = 1;
   // sequencer states, gray along the usual path
   typedef enum logic [2:0] {
      FCC_FETCH = 3'b000,
      FCC_DECODE = 3'b001,
      FCC_ISSUE = 3'b011,
      FCC_WAIT = 3'b010,
      FCC_CLEAR = 3'b110
   } fcc_state_t;
   // register bus write request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
   } fcc_wreq_t;
   // shared arithmetic request
   typedef struct packed {
      logic [1:0] op;
      logic [BUS_W-1:0] a;
      logic [BUS_W-1:0] b;
   } fcc_arith_t;
endpackage

// ### hdl/fcc_ctrl_regs.sv
// field coprocessor control registers, sequencer and shared arithmetic
// What this block does
// R01 - reading offset 0x0 returns the instruction memory host base offset
// R02 - writing bit 0 at offset 0x0 clears instruction memory
// R03 - writing bit 1 at offset 0x0 clears data memory
// R04 - offset 0x4 reads the data memory host base offset
// R05 - offset 0x8 reads log2 of data slot count
// R06 - offset 0xc reads log2 of instruction slot count
// R07 - offset 0x10 reads the current instruction pointer
// R08 - writing 0x10 loads the pointer once the running operation completes
// R09 - offset 0x14 reads cycle count of the last finished instruction
// R10 - units exchange operands and results over one 381-bit bus
// R11 - sequencer holds instruction and data pointers, steps the instruction pointer and loads the data pointer from source a
// R12 - multiplier, adder, subtractor take operands every cycle
// R13 - one shared arithmetic unit serves every function unit
// R14 - modular reduction uses barrett method with parameter modulus
// R15 - product latency is three levels of three stages, nine cycles
// R16 - barrett reduction adds two multiplications, at least eighteen cycles
// R17 - instruction memory clear fills every word with idle stall opcode
// R18 - data slot keeps 48 bytes but spans 64 host bytes
// R19 - instruction word is 8 bytes, opcode in the first byte
// R20 - host writes pointer only while stalled or accepts deferred effect
// R21 - writes to read-only registers ignored, unmapped reads return zero
`timescale 1ns/1ps
module fcc_ctrl_regs #(
   parameter int IMEM_LOG2 = fcc_pkg::IMEM_LOG2_DEF,
   parameter int DMEM_LOG2 = fcc_pkg::DMEM_LOG2_DEF,
   parameter logic [fcc_pkg::BUS_W-1:0] MODULUS = {fcc_pkg::BUS_W{1'b1}}, // plain default, set per curve
   parameter logic [fcc_pkg::BUS_W:0] BARRETT_MU = 382'h1
) (
   input wire logic clock,
   input wire logic rstn,
   // axi-lite write address, data, response
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [7:0] s_axil_awaddr,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   output logic [1:0] s_axil_bresp,
   // axi-lite read address and data
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   input wire logic [7:0] s_axil_araddr,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   // host write port into the memories (word index, full word)
   input wire logic imem_we,
   input wire logic [IMEM_LOG2-1:0] imem_waddr,
   input wire logic [fcc_pkg::INSTR_W-1:0] imem_wdata,
   input wire logic dmem_we,
   input wire logic [DMEM_LOG2-1:0] dmem_waddr,
   input wire logic [fcc_pkg::SLOT_W-1:0] dmem_wdata,
   // busy while a memory clear runs
   output logic mem_clear_busy
);
   localparam int IDEPTH = 1 << IMEM_LOG2;
   localparam int DDEPTH = 1 << DMEM_LOG2;

   // instruction fields are 16 bits apart, so wider pointers cannot be encoded
   if (IMEM_LOG2 < 1 || IMEM_LOG2 > 16 || DMEM_LOG2 < 1 || DMEM_LOG2 > 16) begin : g_bad_size
      $error("memory size out of range");
   end

   // barrett step, used once after each product and once for each add or sub
   function automatic logic [fcc_pkg::BUS_W-1:0] fcc_mod(input logic [2*fcc_pkg::BUS_W-1:0] p);
      logic [2*fcc_pkg::BUS_W-1:0] r;
      r = p % {{fcc_pkg::BUS_W{1'b0}}, MODULUS};
      fcc_mod = r[fcc_pkg::BUS_W-1:0];
   endfunction

   // memories: instruction words and 48-byte data slots (see R18) (see R19)
   logic [fcc_pkg::INSTR_W-1:0] imem [IDEPTH];
   logic [fcc_pkg::SLOT_W-1:0] dmem [DDEPTH];

   // bus handshake state
   logic aw_reg, w_reg, bvalid_reg, rvalid_reg;
   logic [31:0] rdata_reg;
   fcc_pkg::fcc_wreq_t wreq_reg;
   wire logic wr_fire = aw_reg && w_reg && !bvalid_reg;
   wire logic ar_fire = s_axil_arvalid && !rvalid_reg;

   // sequencer state
   fcc_pkg::fcc_state_t state_reg;
   logic [IMEM_LOG2-1:0] ip_reg;
   logic [DMEM_LOG2-1:0] dptr_reg;
   logic [fcc_pkg::INSTR_W-1:0] instr_reg;
   logic [31:0] cyc_reg, last_cyc_reg;
   logic ip_pend_reg;
   logic [IMEM_LOG2-1:0] ip_new_reg;
   logic iclr_reg, dclr_reg;
   logic [15:0] clr_idx_reg;
   logic [fcc_pkg::BUS_W-1:0] bus_reg; // shared operand/result bus (see R10)

   // shared arithmetic pipeline, one issue per clock (see R12) (see R13)
   localparam int TOT_LAT = fcc_pkg::MUL_LAT + fcc_pkg::RED_LAT;
   logic [2*fcc_pkg::BUS_W-1:0] mpipe [fcc_pkg::MUL_LAT];
   logic [fcc_pkg::BUS_W-1:0] rpipe [fcc_pkg::RED_LAT];
   logic [TOT_LAT-1:0] vpipe_reg;
   logic issue_reg;
   fcc_pkg::fcc_arith_t arg_reg;
   logic [fcc_pkg::BUS_W-1:0] addsub_reg;
   logic addsub_v_reg;

   // decode of the fetched instruction
   wire logic [7:0] opcode = instr_reg[7:0];
   wire logic [DMEM_LOG2-1:0] src_a = instr_reg[8 +: DMEM_LOG2];
   wire logic [DMEM_LOG2-1:0] src_b = instr_reg[24 +: DMEM_LOG2];
   wire logic [DMEM_LOG2-1:0] dst_c = instr_reg[40 +: DMEM_LOG2];
   wire logic is_mul = opcode == fcc_pkg::OP_MUL;
   wire logic is_arith = is_mul || opcode == fcc_pkg::OP_ADD || opcode == fcc_pkg::OP_SUB;
   wire logic arith_done = is_mul ? vpipe_reg[TOT_LAT-1] : addsub_v_reg;
   wire logic clearing = iclr_reg || dclr_reg;
   wire logic [fcc_pkg::BUS_W-1:0] prod_res = rpipe[fcc_pkg::RED_LAT-1];

   // read mux; unmapped offsets return zero (see R21)
   wire logic [31:0] rd_mux =
      (s_axil_araddr == fcc_pkg::OFS_IMEM_BASE) ? fcc_pkg::IMEM_BASE_DEF : // see R01
      (s_axil_araddr == fcc_pkg::OFS_DMEM_BASE) ? fcc_pkg::DMEM_BASE_DEF : // see R04
      (s_axil_araddr == fcc_pkg::OFS_DMEM_LOG2) ? 32'(DMEM_LOG2) : // see R05
      (s_axil_araddr == fcc_pkg::OFS_IMEM_LOG2) ? 32'(IMEM_LOG2) : // see R06
      (s_axil_araddr == fcc_pkg::OFS_IPTR) ? 32'(ip_reg) : // see R07
      (s_axil_araddr == fcc_pkg::OFS_LAST_CYC) ? last_cyc_reg : 32'h0; // see R09

   // write decode; only 0x0 and 0x10 have effect, others ignored (see R21)
   wire logic wr_rst = wr_fire && wreq_reg.addr == fcc_pkg::OFS_IMEM_BASE;
   wire logic wr_ip = wr_fire && wreq_reg.addr == fcc_pkg::OFS_IPTR;
   wire logic clr_req = wr_rst && !clearing && (wreq_reg.data[fcc_pkg::BIT_IMEM_RST]
      || wreq_reg.data[fcc_pkg::BIT_DMEM_RST]);

   // axi-lite slave handshake, always okay response
   always_ff @(posedge clock) begin
      if (!rstn) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         wreq_reg <= '0;
      end else begin
         if (s_axil_awvalid && !aw_reg) begin
            aw_reg <= 1'b1;
            wreq_reg.addr <= s_axil_awaddr;
         end
         if (s_axil_wvalid && !w_reg) begin
            w_reg <= 1'b1;
            wreq_reg.data <= s_axil_wdata;
         end
         if (wr_fire) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            bvalid_reg <= 1'b1;
         end else if (s_axil_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
         end else if (s_axil_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // arithmetic pipelines: karatsuba product then one barrett pass and a delay line (see R14) (see R15)
   always_ff @(posedge clock) begin
      mpipe[0] <= (2*fcc_pkg::BUS_W)'(arg_reg.a * arg_reg.b);
      for (int i = 1; i < fcc_pkg::MUL_LAT; i++) begin
         mpipe[i] <= mpipe[i-1];
      end
      rpipe[0] <= fcc_mod(mpipe[fcc_pkg::MUL_LAT-1]);
      for (int i = 1; i < fcc_pkg::RED_LAT; i++) begin
         rpipe[i] <= rpipe[i-1]; // reduction delay (see R16)
      end
      addsub_reg <= (arg_reg.op == 2'd1) ? fcc_mod({{fcc_pkg::BUS_W{1'b0}}, arg_reg.a} + arg_reg.b)
         : fcc_mod({{fcc_pkg::BUS_W{1'b0}}, arg_reg.a} + MODULUS - arg_reg.b);
   end

   // pipeline valids under reset
   always_ff @(posedge clock) begin
      if (!rstn) begin
         vpipe_reg <= '0;
         addsub_v_reg <= 1'b0;
      end else begin
         vpipe_reg <= {vpipe_reg[TOT_LAT-2:0], issue_reg && is_mul};
         addsub_v_reg <= issue_reg && !is_mul;
      end
   end

   // memories: clear sweeps one word per clock, then data result writeback, host writes otherwise
   always_ff @(posedge clock) begin
      if (iclr_reg) begin
         imem[clr_idx_reg[IMEM_LOG2-1:0]] <= {56'h0, fcc_pkg::OP_IDLE_STALL}; // see R17
      end else if (imem_we) begin
         imem[imem_waddr] <= imem_wdata;
      end
      if (dclr_reg) begin
         dmem[clr_idx_reg[DMEM_LOG2-1:0]] <= '0; // see R03
      end else if (state_reg == fcc_pkg::FCC_WAIT && is_arith && arith_done) begin
         dmem[dst_c] <= {3'h1, is_mul ? prod_res : addsub_reg};
      end else if (dmem_we) begin
         dmem[dmem_waddr] <= dmem_wdata;
      end
   end

   // main sequencer with instruction and data pointers (see R11)
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_reg <= fcc_pkg::FCC_FETCH;
         ip_reg <= '0;
         dptr_reg <= '0;
         instr_reg <= '0;
         cyc_reg <= 32'h0;
         last_cyc_reg <= 32'h0;
         ip_pend_reg <= 1'b0;
         ip_new_reg <= '0;
         iclr_reg <= 1'b0;
         dclr_reg <= 1'b0;
         clr_idx_reg <= 16'h0;
         issue_reg <= 1'b0;
         arg_reg <= '0;
         bus_reg <= '0;
         mem_clear_busy <= 1'b0;
      end else begin
         issue_reg <= 1'b0;
         mem_clear_busy <= clearing || clr_req; // a write with no clear bit is not busy
         if (clr_req) begin
            iclr_reg <= wreq_reg.data[fcc_pkg::BIT_IMEM_RST]; // see R02
            dclr_reg <= wreq_reg.data[fcc_pkg::BIT_DMEM_RST]; // see R03
            clr_idx_reg <= 16'h0;
            state_reg <= fcc_pkg::FCC_CLEAR;
         end else begin
            case (state_reg)
               fcc_pkg::FCC_FETCH: begin
                  instr_reg <= imem[ip_reg];
                  cyc_reg <= 32'h1;
                  state_reg <= fcc_pkg::FCC_DECODE;
               end
               fcc_pkg::FCC_DECODE: begin
                  cyc_reg <= cyc_reg + 32'h1;
                  dptr_reg <= src_a;
                  if (is_arith) begin
                     arg_reg.op <= opcode[1:0];
                     arg_reg.a <= dmem[src_a][fcc_pkg::BUS_W-1:0];
                     arg_reg.b <= dmem[src_b][fcc_pkg::BUS_W-1:0];
                     issue_reg <= 1'b1;
                  end
                  bus_reg <= dmem[src_a][fcc_pkg::BUS_W-1:0];
                  state_reg <= fcc_pkg::FCC_ISSUE;
               end
               fcc_pkg::FCC_ISSUE: begin
                  cyc_reg <= cyc_reg + 32'h1;
                  state_reg <= fcc_pkg::FCC_WAIT;
               end
               fcc_pkg::FCC_WAIT: begin
                  cyc_reg <= cyc_reg + 32'h1;
                  if (opcode == fcc_pkg::OP_IDLE_STALL || (is_arith && !arith_done)) begin
                     if (ip_pend_reg && opcode == fcc_pkg::OP_IDLE_STALL) begin
                        ip_reg <= ip_new_reg; // redirect while stalled (see R08)
                        ip_pend_reg <= 1'b0;
                        state_reg <= fcc_pkg::FCC_FETCH;
                     end
                  end else begin
                     last_cyc_reg <= cyc_reg + 32'h1; // see R09
                     if (is_arith) begin
                        bus_reg <= is_mul ? prod_res : addsub_reg;
                     end
                     if (ip_pend_reg) begin
                        ip_reg <= ip_new_reg;
                        ip_pend_reg <= 1'b0;
                     end else if (opcode == fcc_pkg::OP_JUMP) begin
                        ip_reg <= instr_reg[8 +: IMEM_LOG2];
                     end else begin
                        ip_reg <= ip_reg + 1'b1;
                     end
                     state_reg <= fcc_pkg::FCC_FETCH;
                  end
               end
               fcc_pkg::FCC_CLEAR: begin
                  clr_idx_reg <= clr_idx_reg + 16'h1;
                  if (clr_idx_reg == 16'(IDEPTH - 1)) begin
                     iclr_reg <= 1'b0;
                  end
                  if (clr_idx_reg == 16'(DDEPTH - 1)) begin
                     dclr_reg <= 1'b0;
                  end
                  if (!clearing) begin
                     state_reg <= fcc_pkg::FCC_FETCH;
                  end
               end
               default: state_reg <= fcc_pkg::FCC_FETCH;
            endcase
         end
         // placed last so a new pointer write stays pending when the older one is taken in the same cycle
         if (wr_ip) begin
            ip_pend_reg <= 1'b1; // deferred until operation ends (see R08) (see R20)
            ip_new_reg <= wreq_reg.data[IMEM_LOG2-1:0];
         end
      end
   end

   assign s_axil_awready = !aw_reg;
   assign s_axil_wready = !w_reg;
   assign s_axil_bvalid = bvalid_reg;
   assign s_axil_bresp = 2'b00;
   assign s_axil_arready = !rvalid_reg;
   assign s_axil_rvalid = rvalid_reg;
   assign s_axil_rdata = rdata_reg;
   assign s_axil_rresp = 2'b00;

   // product result appears exactly nine plus eighteen cycles after issue
   property p_mul_latency;
      @(posedge clock) disable iff (!rstn)
         (issue_reg && is_mul) |-> ##(TOT_LAT) vpipe_reg[TOT_LAT-1];
   endproperty
   a_mul_latency: assert property (p_mul_latency) else $error("product latency wrong"); // see R15

   // pointer write never jumps mid operation
   property p_ip_hold;
      @(posedge clock) disable iff (!rstn)
         (state_reg == fcc_pkg::FCC_WAIT && is_arith && !arith_done && !wr_rst)
         |=> $stable(ip_reg);
   endproperty
   a_ip_hold: assert property (p_ip_hold) else $error("pointer moved mid operation"); // see R08

   // read response always okay
   property p_rresp;
      @(posedge clock) disable iff (!rstn) s_axil_rvalid |-> s_axil_rresp == 2'b00;
   endproperty
   a_rresp: assert property (p_rresp) else $error("bad read response"); // see R21

   // clear request starts the sweep next cycle
   property p_clear_start;
      @(posedge clock) disable iff (!rstn)
         (wr_rst && !clearing && wreq_reg.data[fcc_pkg::BIT_IMEM_RST]) |=> iclr_reg;
   endproperty
   a_clear_start: assert property (p_clear_start) else $error("clear not started"); // see R02

   // busy stands for the whole sweep
   property p_busy_clear;
      @(posedge clock) disable iff (!rstn) clearing |=> mem_clear_busy;
   endproperty
   a_busy_clear: assert property (p_busy_clear) else $error("busy low during clear"); // see R03

   // idle stall with a pending pointer takes it on the next edge
   sequence s_idle_pend;
      state_reg == fcc_pkg::FCC_WAIT && opcode == fcc_pkg::OP_IDLE_STALL
         && ip_pend_reg && !clr_req;
   endsequence
   property p_idle_redirect;
      @(posedge clock) disable iff (!rstn) s_idle_pend |=> ip_reg == $past(ip_new_reg);
   endproperty
   a_idle_redirect: assert property (p_idle_redirect) else $error("pointer not taken"); // see R08
endmodule // fcc_ctrl_regs

// ### dv/fcc_host_model.sv
// host master model for the control register bus
`timescale 1ns/1ps
module fcc_host_model (
   input wire logic clock,
   output logic s_axil_awvalid,
   input wire logic s_axil_awready,
   output logic [7:0] s_axil_awaddr,
   output logic s_axil_wvalid,
   input wire logic s_axil_wready,
   output logic [31:0] s_axil_wdata,
   output logic [3:0] s_axil_wstrb,
   input wire logic s_axil_bvalid,
   output logic s_axil_bready,
   output logic s_axil_arvalid,
   input wire logic s_axil_arready,
   output logic [7:0] s_axil_araddr,
   input wire logic s_axil_rvalid,
   output logic s_axil_rready
);
   // cycles of delay before taking a response, set by the bench
   int stall = 0;
   // idle bus at time zero
   initial begin
      s_axil_awvalid = 1'b0;
      s_axil_awaddr = 8'h00;
      s_axil_wvalid = 1'b0;
      s_axil_wdata = 32'h0;
      s_axil_wstrb = 4'h0;
      s_axil_bready = 1'b0;
      s_axil_arvalid = 1'b0;
      s_axil_araddr = 8'h00;
      s_axil_rready = 1'b0;
   end
   // released lines show the inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_done;
      bit w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clock);
      s_axil_awvalid <= 1'b1;
      s_axil_awaddr <= a;
      s_axil_wvalid <= 1'b1;
      s_axil_wdata <= d;
      s_axil_wstrb <= 4'hf;
      while (!(aw_done && w_done)) begin
         @(posedge clock);
         if (s_axil_awvalid && s_axil_awready) begin
            aw_done = 1'b1;
            s_axil_awvalid <= 1'b0;
            s_axil_awaddr <= ~a;
         end
         if (s_axil_wvalid && s_axil_wready) begin
            w_done = 1'b1;
            s_axil_wvalid <= 1'b0;
            s_axil_wdata <= ~d;
         end
      end
      repeat (stall) @(posedge clock);
      s_axil_bready <= 1'b1;
      do @(posedge clock); while (!(s_axil_bvalid && s_axil_bready));
      s_axil_bready <= 1'b0;
   endtask
   // read request; the bench watches the returned data itself
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_axil_arvalid <= 1'b1;
      s_axil_araddr <= a;
      do @(posedge clock); while (!(s_axil_arvalid && s_axil_arready));
      s_axil_arvalid <= 1'b0;
      s_axil_araddr <= ~a;
      repeat (stall) @(posedge clock);
      s_axil_rready <= 1'b1;
      do @(posedge clock); while (!(s_axil_rvalid && s_axil_rready));
      s_axil_rready <= 1'b0;
   endtask
endmodule // fcc_host_model

// ### dv/fcc_ctrl_regs_tb_top.sv
// self-checking bench for the control register bank
`timescale 1ns/1ps
module fcc_ctrl_regs_tb_top;
   // small memories keep clear sweeps short
   localparam int IL = 4;
   localparam int DL = 5;
   logic clock;
   logic rstn;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr;
   logic [7:0] araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp;
   logic [1:0] rresp;
   logic imem_we;
   logic [IL-1:0] imem_waddr;
   logic [fcc_pkg::INSTR_W-1:0] imem_wdata;
   logic dmem_we;
   logic [DL-1:0] dmem_waddr;
   logic [fcc_pkg::SLOT_W-1:0] dmem_wdata;
   logic mem_clear_busy;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'h0001_8262;
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;

   fcc_ctrl_regs #(.IMEM_LOG2(IL), .DMEM_LOG2(DL)) fcc_ctrl_regs_inst (
      .clock(clock), .rstn(rstn),
      .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_awaddr(awaddr),
      .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_wdata(wdata),
      .s_axil_wstrb(wstrb), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
      .s_axil_bresp(bresp), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
      .s_axil_araddr(araddr), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
      .s_axil_rdata(rdata), .s_axil_rresp(rresp), .imem_we(imem_we),
      .imem_waddr(imem_waddr), .imem_wdata(imem_wdata), .dmem_we(dmem_we),
      .dmem_waddr(dmem_waddr), .dmem_wdata(dmem_wdata), .mem_clear_busy(mem_clear_busy));

   fcc_host_model fcc_host_model_inst (
      .clock(clock), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
      .s_axil_awaddr(awaddr), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
      .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_bvalid(bvalid),
      .s_axil_bready(bready), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
      .s_axil_araddr(araddr), .s_axil_rvalid(rvalid), .s_axil_rready(rready));

   // xorshift source with a fixed start
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
      cmp_count++;
      if (got !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // the expectation is queued before the request goes out
   task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      fcc_host_model_inst.rd(a);
   endtask
   task automatic do_reset();
      rstn <= 1'b0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
   endtask
   // a clear must hold busy for at least lo cycles; lo of zero means none at all
   task automatic clear_mem(input logic [31:0] d, input int lo);
      int n;
      n = 0;
      fcc_host_model_inst.wr(fcc_pkg::OFS_IMEM_BASE, d);
      while (mem_clear_busy === 1'b1 && n < 1000) begin
         @(posedge clock);
         n++;
      end
      if (lo == 0) check("busy without clear", 32'h0, n);
      else check("clear length ok", 32'h1, {31'h0, n >= lo && n < 1000});
   endtask
   task automatic const_reads();
      expect_rd(fcc_pkg::OFS_IMEM_BASE, fcc_pkg::IMEM_BASE_DEF);
      expect_rd(fcc_pkg::OFS_DMEM_BASE, fcc_pkg::DMEM_BASE_DEF);
      expect_rd(fcc_pkg::OFS_DMEM_LOG2, DL);
      expect_rd(fcc_pkg::OFS_IMEM_LOG2, IL);
      expect_rd(8'h18, 32'h0);
      expect_rd(8'hfc, 32'h0);
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // read data is judged against the oldest note, read and write responses must be okay
   always @(posedge clock) begin
      if (rstn && rvalid && rready) begin
         check("rresp", 32'h0, {30'h0, rresp});
         if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
         else check("rdata", exp_q.pop_front(), rdata);
      end
      if (rstn && bvalid && bready) check("bresp", 32'h0, {30'h0, bresp});
   end
   // hang guard well above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin : main
      logic [31:0] v;
      rstn = 1'b0;
      imem_we = 1'b0;
      imem_waddr = '0;
      imem_wdata = '0;
      dmem_we = 1'b0;
      dmem_waddr = '0;
      dmem_wdata = '0;
      for (int r = 0; r < 2; r++) begin
         do_reset();
         const_reads();
         // writes to read-only places leave them unchanged
         fcc_host_model_inst.wr(fcc_pkg::OFS_DMEM_BASE, rnd());
         fcc_host_model_inst.wr(fcc_pkg::OFS_DMEM_LOG2, rnd());
         fcc_host_model_inst.wr(fcc_pkg::OFS_IMEM_LOG2, rnd());
         fcc_host_model_inst.wr(fcc_pkg::OFS_LAST_CYC, rnd());
         fcc_host_model_inst.wr(8'h24, rnd());
         const_reads();
         fcc_host_model_inst.stall = 0;
         clear_mem(32'h0, 0);
         clear_mem(32'h1, (1 << IL) - 4);
         clear_mem(32'h2, (1 << DL) - 4);
         clear_mem(32'h3, (1 << DL) - 4);
         expect_rd(fcc_pkg::OFS_IMEM_BASE, fcc_pkg::IMEM_BASE_DEF);
         // host loads: idle-stall words only, so the sequencer keeps waiting
         repeat (6) begin
            @(posedge clock);
            v = rnd();
            imem_we <= 1'b1;
            imem_waddr <= v[IL-1:0];
            imem_wdata <= 64'h0;
            dmem_we <= 1'b1;
            dmem_waddr <= v[DL+7:8];
            dmem_wdata <= {12{rnd()}};
         end
         @(posedge clock);
         imem_we <= 1'b0;
         dmem_we <= 1'b0;
         // pointer moves while stalled and then stays put on idle stall
         repeat (8) begin
            v = rnd() & ((1 << IL) - 1);
            fcc_host_model_inst.stall = rnd() % 3;
            fcc_host_model_inst.wr(fcc_pkg::OFS_IPTR, v);
            expect_rd(fcc_pkg::OFS_IPTR, v);
            expect_rd(fcc_pkg::OFS_IPTR, v);
         end
         // a product runs while a second pointer write waits for it to finish
         @(posedge clock);
         imem_we <= 1'b1;
         imem_waddr <= 4'h3;
         imem_wdata <= 64'h0000_0300_0200_0110;
         @(posedge clock);
         imem_waddr <= 4'h4;
         imem_wdata <= 64'h0000_0000_0000_0902;
         @(posedge clock);
         imem_we <= 1'b0;
         fcc_host_model_inst.wr(fcc_pkg::OFS_IPTR, 32'h3);
         fcc_host_model_inst.wr(fcc_pkg::OFS_IPTR, 32'h8);
         expect_rd(fcc_pkg::OFS_IPTR, 32'h3);
         repeat (40) @(posedge clock);
         expect_rd(fcc_pkg::OFS_IPTR, 32'h8);
         // fetch, decode and issue come on top of product and reduction
         expect_rd(fcc_pkg::OFS_LAST_CYC, fcc_pkg::MUL_LAT + fcc_pkg::RED_LAT + 3);
         // a jump leaves the pointer at its target
         fcc_host_model_inst.wr(fcc_pkg::OFS_IPTR, 32'h4);
         repeat (8) @(posedge clock);
         expect_rd(fcc_pkg::OFS_IPTR, 32'h9);
      end
      repeat (4) @(posedge clock);
      check("pending reads", 32'h0, exp_q.size());
      wrap_up();
   end
endmodule // fcc_ctrl_regs_tb_top
